// ===== sim/test_conditional_skip_test_decoder.sv
// Purpose: self-checking bench for the conditional skip test decoder
// Assumes: zero-wait APB, skip result visible one cycle after an executed word
// Notes: a model tracks flags, pending skip and status; the monitor pops expectations
`timescale 1ns/1ps
module test_conditional_skip_test_decoder;
	import cst_pkg::*;
	`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
		$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, instr_valid = 0, portc_latch = 0, ext0_set = 0, conv_set = 0;
	logic [9:0] instr_word = 10'h000;
	logic [3:0] accumulator = 4'h0, pointed_memory_nibble = 4'h0, m_stat = 4'h0;
	logic skip_next, instr_squash, ext0_request_flag, conversion_done_flag, irq;
	logic m_pend = 0, m_ext0 = 0, m_conv = 0, m_en0 = 0, m_en1 = 0;
	logic [7:0] m_cnt = 8'h00;
	logic [31:0] exp_q[$];
	int n_mismatch = 0, num_checks = 0, cycles = 0, seed = 51291;
	cst_skip_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
		.accumulator(accumulator), .pointed_memory_nibble(pointed_memory_nibble),
		.portc_latch(portc_latch), .ext0_set(ext0_set), .conv_set(conv_set),
		.skip_next(skip_next), .instr_squash(instr_squash), .ext0_request_flag(ext0_request_flag),
		.conversion_done_flag(conversion_done_flag), .irq(irq));
	initial begin
		forever #4 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			stop_test;
		end
	end
	// pops the oldest note when a read completes or a valid word's result lands
	always @(posedge pclk) begin
		logic ex, rd, sq;
		logic [31:0] rv, e;
		ex = instr_valid === 1'b1;
		sq = instr_squash;
		rd = psel && penable && !pwrite && pready === 1'b1;
		rv = prdata;
		if (rd) begin
			e = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
			`CHK(rv, e)
		end
		if (ex) begin
			#1;
			e = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
			`CHK({28'h0, sq, skip_next, ext0_request_flag, conversion_done_flag}, e)
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
		logic err;
		@(posedge pclk);
		instr_valid <= 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(x);
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		err = pslverr;
		psel <= 0;
		penable <= 0;
		`CHK(err, xe)
	endtask
	task instr(input logic [9:0] w, input logic [3:0] a, input logic [3:0] m, input logic pc);
		logic sk, nop;
		@(posedge pclk);
		instr_valid <= 1;
		instr_word <= w;
		accumulator <= a;
		pointed_memory_nibble <= m;
		portc_latch <= pc;
		sk = 0;
		nop = 0;
		if (m_pend) begin
			m_pend = 0;
			exp_q.push_back({28'h0, 1'b1, 1'b0, m_ext0, m_conv});
		end else begin
			case (w)
				CST_CODE_ACC_MEM: sk = a == m;
				CST_CODE_EXT0: if (m_en0) nop = 1; else sk = m_ext0;
				CST_CODE_CONV: if (m_en1) nop = 1; else sk = m_conv;
				CST_CODE_PORTC: sk = pc;
				default: sk = 0;
			endcase
			if (sk && w == CST_CODE_EXT0)
				m_ext0 = 0;
			if (sk && w == CST_CODE_CONV)
				m_conv = 0;
			m_pend = sk;
			m_stat[0] = m_stat[0] | sk;
			m_stat[3] = m_stat[3] | nop;
			m_cnt = m_cnt + 8'(sk);
			exp_q.push_back({28'h0, 1'b0, sk, m_ext0, m_conv});
		end
	endtask
	task ev(input logic e0, input logic c0);
		@(posedge pclk);
		instr_valid <= 0;
		ext0_set <= e0;
		conv_set <= c0;
		@(posedge pclk);
		ext0_set <= 0;
		conv_set <= 0;
		m_ext0 |= e0;
		m_conv |= c0;
		m_stat[1] = m_stat[1] | e0;
		m_stat[2] = m_stat[2] | c0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [3:0] a;
		void'($random(seed));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, CST_OFS_IRQ_CTRL_FIRST, 0, 32'h0, 0);
		apb(0, 8'h18, 0, 32'h0, 1);
		for (int i = 0; i < 8; i++) begin
			a = 4'($random(seed));
			instr(CST_CODE_ACC_MEM, a, i[0] ? a : a ^ 4'($random(seed) | 1), 0);
		end
		instr(10'h000, 4'h0, 4'h0, 0);
		ev(1, 1);
		instr(CST_CODE_EXT0, 4'h0, 4'h0, 0);
		instr(CST_CODE_CONV, 4'h0, 4'h0, 0);
		instr(CST_CODE_CONV, 4'h0, 4'h0, 0);
		instr(CST_CODE_EXT0, 4'h0, 4'h0, 0);
		instr(CST_CODE_EXT0, 4'h0, 4'h0, 0);
		instr(CST_CODE_CONV, 4'h0, 4'h0, 0);
		apb(1, CST_OFS_IRQ_CTRL_FIRST, 32'h1, 0, 0);
		apb(1, CST_OFS_IRQ_CTRL_SECOND, 32'h4, 0, 0);
		m_en0 = 1;
		m_en1 = 1;
		ev(1, 1);
		instr(CST_CODE_EXT0, 4'h0, 4'h0, 0);
		instr(CST_CODE_CONV, 4'h0, 4'h0, 0);
		apb(0, CST_OFS_IRQ_CTRL_SECOND, 0, 32'h4, 0);
		apb(1, CST_OFS_IRQ_CTRL_FIRST, 32'h0, 0, 0);
		apb(1, CST_OFS_IRQ_CTRL_SECOND, 32'h0, 0, 0);
		m_en0 = 0;
		m_en1 = 0;
		instr(CST_CODE_CONV, 4'h0, 4'h0, 0);
		instr(CST_CODE_PORTC, 4'h0, 4'h0, 1);
		instr(CST_CODE_PORTC, 4'h0, 4'h0, 1);
		instr(CST_CODE_PORTC, 4'h0, 4'h0, 0);
		instr(CST_CODE_EXT0, 4'h0, 4'h0, 0);
		ev(1, 1);
		apb(0, CST_OFS_FLAGS, 0, 32'h3, 0);
		apb(1, CST_OFS_FLAGS, 32'h3, 0, 0);
		m_ext0 = 0;
		m_conv = 0;
		apb(0, CST_OFS_FLAGS, 0, 32'h0, 0);
		apb(0, CST_OFS_SKIP_COUNT, 0, {24'h0, m_cnt}, 0);
		apb(1, 8'h18, 32'h1, 0, 1);
		apb(0, CST_OFS_INT_STATUS, 0, {28'h0, m_stat}, 0);
		apb(1, CST_OFS_INT_MASK, 32'h8, 0, 0);
		@(posedge pclk);
		#1;
		`CHK(irq, 1'b1)
		apb(1, CST_OFS_INT_STATUS, 32'hF, 0, 0);
		@(posedge pclk);
		#1;
		`CHK(irq, 1'b0)
		apb(0, CST_OFS_INT_STATUS, 0, 32'h0, 0);
		repeat (3) @(posedge pclk);
		`CHK(exp_q.size(), 0)
		stop_test;
	end
endmodule

// ===== verilog/cst_pkg.sv
// Purpose: constants and types for the conditional skip test decoder
// Assumes: 10-bit instruction words, 4-bit data nibbles, APB register access
// Notes: register offsets are byte addresses of aligned 32-bit words
//
// Summary of operation
// - accumulator-versus-memory test, one word, one cycle, skips next when they match
// - external-0 request test decodes from 0000111000, one word, one cycle
// - with external-0 irq enable low, skip next when the external-0 request flag is set
// - an external-0 request test that skips clears the external-0 request flag
// - with external-0 irq enable high, the external-0 test is a no-operation
// - conversion-complete test decodes from 1010000111, one word, one cycle
// - with conversion irq enable low, skip next when the conversion done flag is set
// - a conversion-complete test that skips clears the conversion done flag
// - with conversion irq enable high, the conversion test is a no-operation
// - port C test, one word, one cycle, skips next when the port C latch is one
package cst_pkg;

	localparam logic [9:0] CST_CODE_ACC_MEM = 10'h026;
	localparam logic [9:0] CST_CODE_EXT0 = 10'h038;
	localparam logic [9:0] CST_CODE_CONV = 10'h287;
	localparam logic [9:0] CST_CODE_PORTC = 10'h289;

	localparam logic [7:0] CST_OFS_IRQ_CTRL_FIRST = 8'h00;
	localparam logic [7:0] CST_OFS_IRQ_CTRL_SECOND = 8'h04;
	localparam logic [7:0] CST_OFS_FLAGS = 8'h08;
	localparam logic [7:0] CST_OFS_INT_STATUS = 8'h0C;
	localparam logic [7:0] CST_OFS_INT_MASK = 8'h10;
	localparam logic [7:0] CST_OFS_SKIP_COUNT = 8'h14;

	localparam int CST_BIT_EXT0_EN = 0;
	localparam int CST_BIT_CONV_EN = 2;
	localparam int CST_BIT_FLAG_EXT0 = 0;
	localparam int CST_BIT_FLAG_CONV = 1;
	localparam int CST_BIT_EV_SKIP = 0;
	localparam int CST_BIT_EV_EXT0 = 1;
	localparam int CST_BIT_EV_CONV = 2;
	localparam int CST_BIT_EV_NOP = 3;

	localparam logic [3:0] CST_RST_CTRL = 4'h0;
	localparam logic [3:0] CST_RST_MASK = 4'h0;
	localparam int CST_SKIP_CNT_W = 8;

	typedef enum logic [4:0] {
		CST_OP_NONE = 5'b00001,
		CST_OP_ACC_MEM = 5'b00010,
		CST_OP_EXT0 = 5'b00100,
		CST_OP_CONV = 5'b01000,
		CST_OP_PORTC = 5'b10000
	} cst_op_t;

	typedef enum logic [6:0] {
		CST_REG_NONE = 7'b0000001,
		CST_REG_CTRL1 = 7'b0000010,
		CST_REG_CTRL2 = 7'b0000100,
		CST_REG_FLAGS = 7'b0001000,
		CST_REG_STAT = 7'b0010000,
		CST_REG_MASK = 7'b0100000,
		CST_REG_CNT = 7'b1000000
	} cst_reg_t;

endpackage

// ===== verilog/cst_skip_decoder.sv
// Purpose: decode and execute four one-cycle conditional skip tests
// Assumes: instruction, accumulator, memory nibble and event inputs come from logic on pclk
// Notes: registers reached over APB; one level interrupt from sticky event bits
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cst_skip_decoder #(
	parameter int CNT_W = cst_pkg::CST_SKIP_CNT_W
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic instr_valid, // instruction word present this cycle
	input wire logic [9:0] instr_word, // fetched instruction word
	input wire logic [3:0] accumulator, // accumulator contents
	input wire logic [3:0] pointed_memory_nibble, // nibble at the data pointer address
	input wire logic portc_latch, // port C output latch
	input wire logic ext0_set, // external-0 request event pulse
	input wire logic conv_set, // conversion complete event pulse
	output logic skip_next, // next instruction will be skipped
	output logic instr_squash, // current instruction is being skipped
	output logic ext0_request_flag, // external-0 request flag
	output logic conversion_done_flag, // conversion completion flag
	output logic irq // interrupt, high while an unmasked status bit is set
);
	import cst_pkg::*;

	if (CNT_W < 1 || CNT_W > 32) begin : g_chk
		$error("CNT_W must lie between 1 and 32");
	end

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic ext0_flag;
		logic conv_flag;
		logic skip_pend;
		logic [3:0] ctrl_first;
		logic [3:0] ctrl_second;
		logic [3:0] int_stat;
		logic [3:0] int_mask;
		logic [CNT_W-1:0] skip_cnt;
		logic [31:0] rdata;
	} cst_state_t;

	cst_state_t st_ff;
	cst_state_t nxt_st;

	function automatic cst_op_t decode_op(input logic [9:0] w);
		cst_op_t r;
		r = CST_OP_NONE;
		if (w == CST_CODE_ACC_MEM) r = CST_OP_ACC_MEM;
		if (w == CST_CODE_EXT0) r = CST_OP_EXT0;
		if (w == CST_CODE_CONV) r = CST_OP_CONV;
		if (w == CST_CODE_PORTC) r = CST_OP_PORTC;
		return r;
	endfunction

	function automatic cst_reg_t decode_reg(input logic [7:0] a);
		cst_reg_t r;
		r = CST_REG_NONE;
		if (a == CST_OFS_IRQ_CTRL_FIRST) r = CST_REG_CTRL1;
		if (a == CST_OFS_IRQ_CTRL_SECOND) r = CST_REG_CTRL2;
		if (a == CST_OFS_FLAGS) r = CST_REG_FLAGS;
		if (a == CST_OFS_INT_STATUS) r = CST_REG_STAT;
		if (a == CST_OFS_INT_MASK) r = CST_REG_MASK;
		if (a == CST_OFS_SKIP_COUNT) r = CST_REG_CNT;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	cst_op_t op;
	cst_reg_t wsel;
	cst_reg_t rsel;
	logic exec;
	logic take;
	logic [3:0] ev;
	logic apb_wr;
	logic [1:0] flag_clr;

	assign op = decode_op(instr_word);
	assign wsel = decode_reg(paddr);
	// a skipped word is swallowed here so it cannot test or clear anything
	assign instr_squash = instr_valid & st_ff.skip_pend;
	assign exec = instr_valid & ~st_ff.skip_pend;
	assign apb_wr = psel & penable & pwrite;
	assign flag_clr = (apb_wr && wsel == CST_REG_FLAGS) ? pwdata[1:0] : 2'b00;

	always_comb begin
		nxt_st = st_ff;
		take = 1'b0;
		ev = 4'h0;
		rsel = decode_reg(paddr);
		if (instr_valid) begin
			nxt_st.skip_pend = 1'b0;
		end
		// only the skip state, skip count, status bits and the two flags change; carry, accumulator and memory are never driven
		if (exec) begin
			unique case (op)
				CST_OP_NONE: begin
					take = 1'b0;
				end
				CST_OP_ACC_MEM: begin
					take = (accumulator == pointed_memory_nibble);
				end
				CST_OP_EXT0: begin
					if (!st_ff.ctrl_first[CST_BIT_EXT0_EN]) begin
						take = st_ff.ext0_flag;
						if (st_ff.ext0_flag) begin
							nxt_st.ext0_flag = 1'b0;
						end
					end else begin
						ev[CST_BIT_EV_NOP] = 1'b1;
					end
				end
				CST_OP_CONV: begin
					if (!st_ff.ctrl_second[CST_BIT_CONV_EN]) begin
						take = st_ff.conv_flag;
						if (st_ff.conv_flag) begin
							nxt_st.conv_flag = 1'b0;
						end
					end else begin
						ev[CST_BIT_EV_NOP] = 1'b1;
					end
				end
				CST_OP_PORTC: begin
					take = portc_latch;
				end
			endcase
		end
		if (take) begin
			nxt_st.skip_pend = 1'b1;
			nxt_st.skip_cnt = st_ff.skip_cnt + 1'b1;
		end
		ev[CST_BIT_EV_SKIP] = take;
		ev[CST_BIT_EV_EXT0] = ext0_set;
		ev[CST_BIT_EV_CONV] = conv_set;
		// software clear first, hardware set afterwards: a same-cycle event survives
		if (flag_clr[CST_BIT_FLAG_EXT0]) begin
			nxt_st.ext0_flag = 1'b0;
		end
		if (flag_clr[CST_BIT_FLAG_CONV]) begin
			nxt_st.conv_flag = 1'b0;
		end
		if (ext0_set) begin
			nxt_st.ext0_flag = 1'b1;
		end
		if (conv_set) begin
			nxt_st.conv_flag = 1'b1;
		end
		if (apb_wr) begin
			unique case (wsel)
				CST_REG_NONE, CST_REG_FLAGS, CST_REG_CNT: begin
					nxt_st.int_stat = st_ff.int_stat;
				end
				CST_REG_CTRL1: begin
					nxt_st.ctrl_first = pwdata[3:0];
				end
				CST_REG_CTRL2: begin
					nxt_st.ctrl_second = pwdata[3:0];
				end
				CST_REG_STAT: begin
					nxt_st.int_stat = st_ff.int_stat & ~pwdata[3:0];
				end
				CST_REG_MASK: begin
					nxt_st.int_mask = pwdata[3:0];
				end
			endcase
		end
		nxt_st.int_stat = nxt_st.int_stat | ev;
		// read data is captured in the setup phase so prdata leaves a flip-flop
		if (psel && !penable && !pwrite) begin
			nxt_st.rdata = 32'h0000_0000;
			unique case (rsel)
				CST_REG_NONE: begin
					nxt_st.rdata = 32'h0000_0000;
				end
				CST_REG_CTRL1: begin
					nxt_st.rdata[3:0] = st_ff.ctrl_first;
				end
				CST_REG_CTRL2: begin
					nxt_st.rdata[3:0] = st_ff.ctrl_second;
				end
				CST_REG_FLAGS: begin
					nxt_st.rdata[1:0] = {st_ff.conv_flag, st_ff.ext0_flag};
				end
				CST_REG_STAT: begin
					nxt_st.rdata[3:0] = st_ff.int_stat;
				end
				CST_REG_MASK: begin
					nxt_st.rdata[3:0] = st_ff.int_mask;
				end
				CST_REG_CNT: begin
					nxt_st.rdata[CNT_W-1:0] = st_ff.skip_cnt;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{ext0_flag: 1'b0, conv_flag: 1'b0, skip_pend: 1'b0,
				ctrl_first: CST_RST_CTRL, ctrl_second: CST_RST_CTRL, int_stat: 4'h0,
				int_mask: CST_RST_MASK, skip_cnt: '0, rdata: 32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign prdata = st_ff.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & (wsel == CST_REG_NONE);
	assign skip_next = st_ff.skip_pend;
	assign ext0_request_flag = st_ff.ext0_flag;
	assign conversion_done_flag = st_ff.conv_flag;
	assign irq = |(st_ff.int_stat & st_ff.int_mask);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic quiet_ext0;
	logic quiet_conv;
	assign quiet_ext0 = !ext0_set && !flag_clr[CST_BIT_FLAG_EXT0];
	assign quiet_conv = !conv_set && !flag_clr[CST_BIT_FLAG_CONV];

	sequence s_ext0_hit;
		exec && instr_word == CST_CODE_EXT0 && !st_ff.ctrl_first[CST_BIT_EXT0_EN] && ext0_request_flag;
	endsequence
	sequence s_conv_hit;
		exec && instr_word == CST_CODE_CONV && !st_ff.ctrl_second[CST_BIT_CONV_EN] && conversion_done_flag;
	endsequence

	property p_acc_mem;
		exec && instr_word == CST_CODE_ACC_MEM |=> skip_next == $past(accumulator == pointed_memory_nibble);
	endproperty
	a_acc_mem: assert property (p_acc_mem) else $error("acc-mem test skip wrong");

	property p_ext0_one_cycle;
		s_ext0_hit ##1 instr_valid |-> instr_squash;
	endproperty
	a_ext0_one_cycle: assert property (p_ext0_one_cycle) else $error("ext0 test not done in one cycle");

	property p_ext0_skip;
		exec && instr_word == CST_CODE_EXT0 && !st_ff.ctrl_first[CST_BIT_EXT0_EN]
			|=> skip_next == $past(ext0_request_flag);
	endproperty
	a_ext0_skip: assert property (p_ext0_skip) else $error("ext0 test skip wrong");

	property p_ext0_clear;
		s_ext0_hit and (!ext0_set) |=> !ext0_request_flag;
	endproperty
	a_ext0_clear: assert property (p_ext0_clear) else $error("ext0 flag not cleared on skip");

	property p_ext0_nop;
		exec && instr_word == CST_CODE_EXT0 && st_ff.ctrl_first[CST_BIT_EXT0_EN] && quiet_ext0
			|=> !skip_next && $stable(ext0_request_flag);
	endproperty
	a_ext0_nop: assert property (p_ext0_nop) else $error("disabled ext0 test not a nop");

	property p_conv_one_cycle;
		s_conv_hit ##1 instr_valid |-> instr_squash;
	endproperty
	a_conv_one_cycle: assert property (p_conv_one_cycle) else $error("conv test not done in one cycle");

	property p_conv_skip;
		exec && instr_word == CST_CODE_CONV && !st_ff.ctrl_second[CST_BIT_CONV_EN]
			|=> skip_next == $past(conversion_done_flag);
	endproperty
	a_conv_skip: assert property (p_conv_skip) else $error("conv test skip wrong");

	property p_conv_clear;
		s_conv_hit and (!conv_set) |=> !conversion_done_flag;
	endproperty
	a_conv_clear: assert property (p_conv_clear) else $error("conv flag not cleared on skip");

	property p_conv_nop;
		exec && instr_word == CST_CODE_CONV && st_ff.ctrl_second[CST_BIT_CONV_EN] && quiet_conv
			|=> !skip_next && $stable(conversion_done_flag);
	endproperty
	a_conv_nop: assert property (p_conv_nop) else $error("disabled conv test not a nop");

	property p_portc;
		exec && instr_word == CST_CODE_PORTC |=> skip_next == $past(portc_latch);
	endproperty
	a_portc: assert property (p_portc) else $error("port C test skip wrong");

	property p_squash_inert;
		instr_squash && quiet_ext0 && quiet_conv
			|=> !skip_next && $stable(ext0_request_flag) && $stable(conversion_done_flag);
	endproperty
	a_squash_inert: assert property (p_squash_inert) else $error("skipped instruction had an effect");

	property p_flag_set_wins;
		ext0_set |=> ext0_request_flag;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("ext0 event lost");

	// an unmasked event must raise irq on the next cycle, even against a same-cycle status clear
	property p_irq_level;
		|(ev & st_ff.int_mask) && !(apb_wr && wsel == CST_REG_MASK) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_conv_set_wins;
		conv_set |=> conversion_done_flag;
	endproperty
	a_conv_set_wins: assert property (p_conv_set_wins) else $error("conv event lost");

	property p_ext0_sw_clear;
		flag_clr[CST_BIT_FLAG_EXT0] && !ext0_set |=> !ext0_request_flag;
	endproperty
	a_ext0_sw_clear: assert property (p_ext0_sw_clear) else $error("ext0 flag not cleared by software");

	property p_conv_sw_clear;
		flag_clr[CST_BIT_FLAG_CONV] && !conv_set |=> !conversion_done_flag;
	endproperty
	a_conv_sw_clear: assert property (p_conv_sw_clear) else $error("conv flag not cleared by software");

	sequence s_skip_taken;
		exec && take;
	endsequence

	property p_skip_count;
		s_skip_taken |=> st_ff.skip_cnt == CNT_W'($past(st_ff.skip_cnt) + 1'b1);
	endproperty
	a_skip_count: assert property (p_skip_count) else $error("skip counter did not advance");

	property p_skip_status;
		s_skip_taken |=> st_ff.int_stat[CST_BIT_EV_SKIP];
	endproperty
	a_skip_status: assert property (p_skip_status) else $error("skip status bit lost");

	property p_squash_no_count;
		instr_squash |=> $stable(st_ff.skip_cnt);
	endproperty
	a_squash_no_count: assert property (p_squash_no_count) else $error("skipped word was counted");

	property p_nop_status;
		ev[CST_BIT_EV_NOP] |=> st_ff.int_stat[CST_BIT_EV_NOP] && !skip_next;
	endproperty
	a_nop_status: assert property (p_nop_status) else $error("disabled test status wrong");

endmodule
